/* bank_tracker.sv */
`timescale 1ns/10ps
module bank_tracker #(
    parameter int CLOSE_CYCLES = 3,
    parameter int OPEN_CYCLES = 3
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Accepted commands for this bank.
    input wire logic openRow,
    input wire logic closeRow,
    input wire logic autoAccess,
    input wire logic [ddr_legality_pkg::BANK_COUNT_WIDTH-1:0] accessCycles,
    // Bank state.
    output ddr_legality_pkg::bank_state_type bankState
);
    import ddr_legality_pkg::*;

    if (CLOSE_CYCLES < 1 || CLOSE_CYCLES > 255 || OPEN_CYCLES < 1 || OPEN_CYCLES > 255) begin : bad_timing
        $error("bank_tracker: cycle counts must lie in 1..255");
    end

    localparam logic [BANK_COUNT_WIDTH-1:0] CLOSE_LAST = BANK_COUNT_WIDTH'(CLOSE_CYCLES - 1);
    localparam logic [BANK_COUNT_WIDTH-1:0] OPEN_LAST = BANK_COUNT_WIDTH'(OPEN_CYCLES - 1);

    bank_tracker_state_type st;
    bank_tracker_state_type next_st;

    always_comb begin
        next_st = st;
        if (st.count != BANK_COUNT_RESET) begin
            next_st.count = st.count - 8'h01;
        end
        case (st.state)
            BANK_IDLE: begin
                if (openRow) begin
                    next_st.state = BANK_OPENING;
                    next_st.count = OPEN_LAST;
                end else if (closeRow) begin
                    next_st.state = BANK_CLOSING;
                    next_st.count = CLOSE_LAST;
                end
            end
            BANK_OPENING: begin
                if (st.count == BANK_COUNT_RESET) begin
                    next_st.state = BANK_ACTIVE;
                end
            end
            BANK_ACTIVE: begin
                if (closeRow) begin
                    next_st.state = BANK_CLOSING;
                    next_st.count = CLOSE_LAST;
                end else if (autoAccess) begin
                    next_st.state = BANK_AUTO_ACCESS;
                    next_st.count = accessCycles - 8'h01;
                end
            end
            BANK_CLOSING: begin
                if (st.count == BANK_COUNT_RESET) begin
                    next_st.state = BANK_IDLE;
                end
            end
            BANK_AUTO_ACCESS: begin
                if (st.count == BANK_COUNT_RESET) begin
                    next_st.state = BANK_AUTO_CLOSING;
                    next_st.count = CLOSE_LAST;
                end
            end
            BANK_AUTO_CLOSING: begin
                if (st.count == BANK_COUNT_RESET) begin
                    next_st.state = BANK_IDLE;
                end
            end
            default: begin
                next_st.state = BANK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st.state <= BANK_IDLE;
            st.count <= BANK_COUNT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign bankState = st.state;

endmodule : bank_tracker

/* ddr_bank_command_legality.sv */
`timescale 1ns/10ps
module ddr_bank_command_legality #(
    parameter int BANK_CLOSE_TIME_CYCLES = ddr_legality_pkg::BANK_CLOSE_CYCLES_DEFAULT,
    parameter int ROW_TO_COLUMN_DELAY_CYCLES = ddr_legality_pkg::ROW_TO_COLUMN_CYCLES_DEFAULT,
    parameter int REFRESH_CYCLE_TIME_CYCLES = ddr_legality_pkg::REFRESH_CYCLE_CYCLES_DEFAULT,
    parameter int CONFIG_LOAD_DELAY_CYCLES = ddr_legality_pkg::CONFIG_LOAD_CYCLES_DEFAULT,
    parameter int WRITE_RECOVERY_CYCLES = ddr_legality_pkg::WRITE_RECOVERY_CYCLES_DEFAULT,
    parameter int READ_LATENCY_COUNT = ddr_legality_pkg::READ_LATENCY_DEFAULT,
    parameter int BURST_LENGTH = ddr_legality_pkg::BURST_LENGTH_DEFAULT,
    parameter bit CONCURRENT_AUTO_PRECHARGE = 1'b0,
    parameter int POWER_STABLE_WAIT = ddr_legality_pkg::POWER_STABLE_CYCLES
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Command pins sampled at the rising edge.
    input wire logic clockEnable,
    input wire ddr_legality_pkg::command_pins_type commandPins,
    // Per-bank status.
    output ddr_legality_pkg::bank_state_type [ddr_legality_pkg::BANK_COUNT-1:0] bankStates,
    output logic [ddr_legality_pkg::BANK_COUNT-1:0] bankRowReady,
    output logic allBanksIdle,
    // Device status.
    output ddr_legality_pkg::global_op_type deviceOp,
    output logic deviceBusy,
    output logic readDataDrive,
    output logic [1:0] readBurstBank,
    // Error reporting.
    output logic commandViolation,
    output logic reinitRequired
);
    import ddr_legality_pkg::*;

    localparam int HALF_BURST = BURST_LENGTH / 2;

    if (!(BURST_LENGTH == 2 || BURST_LENGTH == 4 || BURST_LENGTH == 8) || READ_LATENCY_COUNT < 1
        || READ_LATENCY_COUNT > 8 || POWER_STABLE_WAIT < 1 || POWER_STABLE_WAIT > 65535
        || REFRESH_CYCLE_TIME_CYCLES < 1 || CONFIG_LOAD_DELAY_CYCLES < 1 || WRITE_RECOVERY_CYCLES < 0
        || WRITE_RECOVERY_CYCLES > 200 || REFRESH_CYCLE_TIME_CYCLES > 65535) begin : bad_params
        $error("ddr_bank_command_legality: parameter out of range");
    end

    localparam logic [GLOBAL_COUNT_WIDTH-1:0] POWER_LAST = GLOBAL_COUNT_WIDTH'(POWER_STABLE_WAIT - 1);
    localparam logic [GLOBAL_COUNT_WIDTH-1:0] REFRESH_LAST = GLOBAL_COUNT_WIDTH'(REFRESH_CYCLE_TIME_CYCLES - 1);
    localparam logic [GLOBAL_COUNT_WIDTH-1:0] CONFIG_LAST = GLOBAL_COUNT_WIDTH'(CONFIG_LOAD_DELAY_CYCLES - 1);
    localparam logic [GLOBAL_COUNT_WIDTH-1:0] CLOSE_ALL_LAST = GLOBAL_COUNT_WIDTH'(BANK_CLOSE_TIME_CYCLES - 1);
    localparam logic [LOCK_COUNT_WIDTH-1:0] LOCK_LOAD = LOCK_COUNT_WIDTH'(LOCK_CYCLES);
    localparam logic [BURST_COUNT_WIDTH-1:0] LATENCY = BURST_COUNT_WIDTH'(READ_LATENCY_COUNT);
    localparam logic [BURST_COUNT_WIDTH-1:0] HALF = BURST_COUNT_WIDTH'(HALF_BURST);
    localparam logic [BURST_COUNT_WIDTH-1:0] READ_SPAN = BURST_COUNT_WIDTH'(READ_LATENCY_COUNT + HALF_BURST);
    localparam logic [BURST_COUNT_WIDTH-1:0] WRITE_SPAN = BURST_COUNT_WIDTH'(WRITE_LATENCY_CYCLES + HALF_BURST);
    // Access period of an auto-precharge read ends where the earliest full-data precharge could go.
    localparam logic [BANK_COUNT_WIDTH-1:0] READ_ACCESS = BANK_COUNT_WIDTH'(HALF_BURST);
    // Access period of an auto-precharge write ends when write recovery is over.
    localparam logic [BANK_COUNT_WIDTH-1:0] WRITE_ACCESS =
        BANK_COUNT_WIDTH'(WRITE_LATENCY_CYCLES + HALF_BURST + WRITE_RECOVERY_CYCLES);

    legality_state_type st;
    legality_state_type next_st;
    command_decoded_type cmd;
    logic commandLegal;
    logic badCommand;
    logic burstActive;
    logic [BANK_COUNT-1:0] bankBusy;
    logic [BANK_COUNT-1:0] bankIdle;
    logic [BANK_COUNT-1:0] openRow;
    logic [BANK_COUNT-1:0] closeRow;
    logic [BANK_COUNT-1:0] autoAccess;
    logic [BANK_COUNT_WIDTH-1:0] accessCycles;

    // Only decode while the clock enable was high on this edge and the one before.
    always_comb begin
        cmd.op = CMD_NONE;
        cmd.bank = commandPins.bank;
        cmd.autoPrecharge = commandPins.autoPrecharge;
        if (clockEnable && st.ckePrev && !commandPins.chipSelectN) begin
            case ({commandPins.rowStrobeN, commandPins.columnStrobeN, commandPins.writeStrobeN})
                3'h3: cmd.op = CMD_ACTIVATE;
                3'h1: cmd.op = CMD_REFRESH;
                3'h0: cmd.op = CMD_CONFIG_LOAD;
                3'h5: cmd.op = CMD_READ;
                3'h4: cmd.op = CMD_WRITE;
                3'h2: cmd.op = CMD_PRECHARGE;
                3'h6: cmd.op = CMD_BURST_STOP;
                default: cmd.op = CMD_NONE;
            endcase
        end
    end

    always_comb begin
        for (int i = 0; i < BANK_COUNT; i++) begin
            bankIdle[i] = bankStates[i] == BANK_IDLE;
            bankBusy[i] = bankStates[i] == BANK_OPENING || bankStates[i] == BANK_CLOSING
                || bankStates[i] == BANK_AUTO_ACCESS || bankStates[i] == BANK_AUTO_CLOSING;
            bankRowReady[i] = bankStates[i] == BANK_ACTIVE
                && !(st.readEnd != BURST_COUNT_RESET && st.readBank == 2'(i));
        end
    end

    assign burstActive = st.readEnd != BURST_COUNT_RESET || st.writeEnd != BURST_COUNT_RESET;
    assign allBanksIdle = &bankIdle;

    // Judge the command against the device and bank states.
    always_comb begin
        badCommand = 1'b0;
        if (cmd.op != CMD_NONE && st.op != OP_READY) begin
            badCommand = 1'b1;
        end else begin
            case (cmd.op)
                CMD_ACTIVATE: begin
                    if (st.lockCount != LOCK_COUNT_RESET || !bankIdle[cmd.bank]) begin
                        badCommand = 1'b1;
                    end
                end
                CMD_READ, CMD_WRITE: begin
                    if (st.lockCount != LOCK_COUNT_RESET || bankStates[cmd.bank] != BANK_ACTIVE) begin
                        badCommand = 1'b1;
                    end
                    for (int i = 0; i < BANK_COUNT; i++) begin
                        if (!CONCURRENT_AUTO_PRECHARGE && 2'(i) != cmd.bank && bankStates[i] == BANK_AUTO_ACCESS) begin
                            badCommand = 1'b1;
                        end
                    end
                    if (cmd.op == CMD_WRITE && st.readEnd > LATENCY) begin
                        badCommand = 1'b1;
                    end
                end
                CMD_PRECHARGE: begin
                    if (cmd.autoPrecharge) begin
                        if (|bankBusy) begin
                            badCommand = 1'b1;
                        end
                    end else if (bankBusy[cmd.bank]) begin
                        badCommand = 1'b1;
                    end
                end
                CMD_REFRESH, CMD_CONFIG_LOAD: begin
                    if (!allBanksIdle || burstActive) begin
                        badCommand = 1'b1;
                    end
                end
                default: badCommand = 1'b0;
            endcase
        end
    end

    assign commandLegal = cmd.op != CMD_NONE && !badCommand;

    always_comb begin
        for (int i = 0; i < BANK_COUNT; i++) begin
            openRow[i] = commandLegal && cmd.op == CMD_ACTIVATE && cmd.bank == 2'(i);
            closeRow[i] = commandLegal && cmd.op == CMD_PRECHARGE && (cmd.autoPrecharge || cmd.bank == 2'(i));
            autoAccess[i] = commandLegal && (cmd.op == CMD_READ || cmd.op == CMD_WRITE)
                && cmd.autoPrecharge && cmd.bank == 2'(i);
        end
        accessCycles = cmd.op == CMD_READ ? READ_ACCESS : WRITE_ACCESS;
    end

    for (genvar b = 0; b < BANK_COUNT; b++) begin : banks
        bank_tracker #(
            .CLOSE_CYCLES(BANK_CLOSE_TIME_CYCLES),
            .OPEN_CYCLES(ROW_TO_COLUMN_DELAY_CYCLES)
        ) tracker (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .openRow(openRow[b]),
            .closeRow(closeRow[b]),
            .autoAccess(autoAccess[b]),
            .accessCycles(accessCycles),
            .bankState(bankStates[b])
        );
    end

    always_comb begin
        next_st = st;
        next_st.ckePrev = clockEnable;
        next_st.violation = badCommand;
        next_st.reinit = st.reinit | badCommand;
        if (st.lockCount != LOCK_COUNT_RESET) begin
            next_st.lockCount = st.lockCount - 8'h01;
        end
        if (st.readEnd != BURST_COUNT_RESET) begin
            next_st.readEnd = st.readEnd - 6'h01;
        end
        if (st.writeEnd != BURST_COUNT_RESET) begin
            next_st.writeEnd = st.writeEnd - 6'h01;
        end
        next_st.count = st.count + 16'h0001;
        case (st.op)
            OP_POWER_WAIT: begin
                if (st.count == POWER_LAST) begin
                    next_st.op = OP_READY;
                    next_st.count = GLOBAL_COUNT_RESET;
                end
            end
            OP_REFRESH: begin
                if (st.count == REFRESH_LAST) begin
                    next_st.op = OP_READY;
                    next_st.count = GLOBAL_COUNT_RESET;
                end
            end
            OP_CONFIG_LOAD: begin
                if (st.count == CONFIG_LAST) begin
                    next_st.op = OP_READY;
                    next_st.count = GLOBAL_COUNT_RESET;
                end
            end
            OP_READY: begin
                next_st.count = GLOBAL_COUNT_RESET;
                if (st.closeAll) begin
                    next_st.count = st.count + 16'h0001;
                    if (st.count == CLOSE_ALL_LAST) begin
                        next_st.closeAll = 1'b0;
                        next_st.count = GLOBAL_COUNT_RESET;
                    end
                end
            end
            default: begin
                next_st.op = OP_READY;
                next_st.count = GLOBAL_COUNT_RESET;
            end
        endcase
        if (commandLegal) begin
            case (cmd.op)
                CMD_REFRESH: begin
                    next_st.op = OP_REFRESH;
                    next_st.count = GLOBAL_COUNT_RESET;
                end
                CMD_CONFIG_LOAD: begin
                    next_st.op = OP_CONFIG_LOAD;
                    next_st.count = GLOBAL_COUNT_RESET;
                    next_st.lockCount = LOCK_LOAD;
                end
                CMD_READ: begin
                    next_st.readEnd = READ_SPAN;
                    next_st.readBank = cmd.bank;
                end
                CMD_WRITE: begin
                    next_st.writeEnd = WRITE_SPAN;
                    if (st.readEnd > LATENCY) begin
                        next_st.readEnd = LATENCY;
                    end
                end
                CMD_PRECHARGE: begin
                    if (cmd.autoPrecharge) begin
                        next_st.closeAll = 1'b1;
                        next_st.count = GLOBAL_COUNT_RESET;
                    end
                    if ((cmd.autoPrecharge || cmd.bank == st.readBank) && st.readEnd > LATENCY) begin
                        next_st.readEnd = LATENCY;
                    end
                end
                CMD_BURST_STOP: begin
                    if (st.readEnd > LATENCY) begin
                        next_st.readEnd = LATENCY;
                    end
                end
                default: next_st.readBank = st.readBank;
            endcase
        end
        // Data pins are driven only in the data window; after the last word they are released.
        next_st.dataDrive = next_st.readEnd != BURST_COUNT_RESET && next_st.readEnd <= HALF;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st.op <= OP_POWER_WAIT;
            st.closeAll <= 1'b0;
            st.count <= GLOBAL_COUNT_RESET;
            st.lockCount <= LOCK_COUNT_RESET;
            st.ckePrev <= 1'b0;
            st.readEnd <= BURST_COUNT_RESET;
            st.writeEnd <= BURST_COUNT_RESET;
            st.readBank <= 2'h0;
            st.dataDrive <= 1'b0;
            st.violation <= 1'b0;
            st.reinit <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign deviceOp = st.op;
    assign deviceBusy = st.op != OP_READY || st.closeAll;
    assign readDataDrive = st.dataDrive;
    assign readBurstBank = st.readBank;
    assign commandViolation = st.violation;
    assign reinitRequired = st.reinit;

endmodule : ddr_bank_command_legality

/* ddr_bank_command_legality_bench.sv */
`timescale 1ns/10ps
module ddr_bank_command_legality_bench;
    import ddr_legality_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic clockEnable, allBanksIdle, deviceBusy, readDataDrive, commandViolation, reinitRequired;
    command_pins_type commandPins;
    bank_state_type [BANK_COUNT-1:0] bankStates;
    logic [BANK_COUNT-1:0] bankRowReady;
    global_op_type deviceOp;
    logic [1:0] readBurstBank;
    int bad_count = 0;
    int total_checks = 0;
    int n;
    always #5 clk_sys = ~clk_sys;
    ddr_controller_model i_ctrl (.clk_sys, .clockEnable, .commandPins);
    ddr_bank_command_legality #(.BURST_LENGTH(8), .POWER_STABLE_WAIT(20)) i_dut (.clk_sys, .resetn, .clockEnable,
        .commandPins, .bankStates, .bankRowReady, .allBanksIdle, .deviceOp, .deviceBusy, .readDataDrive,
        .readBurstBank, .commandViolation, .reinitRequired);
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Counts cycles while a bank (0..3) or the device (4) stays in one state.
    task span(input int sel, input logic [2:0] v, input int exp);
        int k;
        k = 0;
        while ((sel < 4 ? bankStates[sel] === v : deviceOp === v[1:0]) && k < 40) begin
            k++;
            @(negedge clk_sys);
        end
        chk(16'(k), 16'(exp));
    endtask : span
    task drive_count;
        n = 0;
        repeat (8) begin
            n += int'(readDataDrive);
            @(negedge clk_sys);
        end
    endtask : drive_count
    task t_reset;
        chk(allBanksIdle, 1'b1);
        i_ctrl.issue(CMD_ACTIVATE, 2'h0, 1'b0);
        chk(commandViolation, 1'b1);
        chk(bankStates[0], BANK_IDLE);
        repeat (40) if (deviceOp !== OP_READY) @(negedge clk_sys);
        chk(reinitRequired, 1'b1);
        $display("reset test done");
    endtask : t_reset
    task t_global;
        i_ctrl.issue(CMD_REFRESH, 2'h0, 1'b0);
        span(4, OP_REFRESH, REFRESH_CYCLE_CYCLES_DEFAULT);
        i_ctrl.issue(CMD_CONFIG_LOAD, 2'h0, 1'b0);
        span(4, OP_CONFIG_LOAD, CONFIG_LOAD_CYCLES_DEFAULT);
        i_ctrl.issue(CMD_ACTIVATE, 2'h0, 1'b0);
        chk(commandViolation, 1'b1);
        repeat (LOCK_CYCLES) @(negedge clk_sys);
        $display("global test done");
    endtask : t_global
    task t_bank;
        i_ctrl.issue(CMD_ACTIVATE, 2'h0, 1'b0);
        i_ctrl.issue(CMD_ACTIVATE, 2'h0, 1'b0);
        chk(commandViolation, 1'b1);
        span(0, BANK_OPENING, ROW_TO_COLUMN_CYCLES_DEFAULT - 1);
        chk(bankRowReady[0], 1'b1);
        i_ctrl.issue(CMD_PRECHARGE, 2'h0, 1'b0);
        span(0, BANK_CLOSING, BANK_CLOSE_CYCLES_DEFAULT);
        chk(bankStates[0], BANK_IDLE);
        $display("bank test done");
    endtask : t_bank
    task t_auto;
        i_ctrl.issue(CMD_ACTIVATE, 2'h1, 1'b0);
        i_ctrl.issue(CMD_ACTIVATE, 2'h2, 1'b0);
        repeat (3) @(negedge clk_sys);
        i_ctrl.issue(CMD_READ, 2'h1, 1'b1);
        i_ctrl.issue(CMD_READ, 2'h2, 1'b0);
        chk(commandViolation, 1'b1);
        span(1, BANK_AUTO_ACCESS, 3);
        span(1, BANK_AUTO_CLOSING, BANK_CLOSE_CYCLES_DEFAULT);
        chk(bankStates[1], BANK_IDLE);
        $display("auto precharge test done");
    endtask : t_auto
    task t_read;
        i_ctrl.issue(CMD_READ, 2'h2, 1'b0);
        chk(readBurstBank, 2'h2);
        i_ctrl.issue(CMD_WRITE, 2'h2, 1'b0);
        chk(commandViolation, 1'b1);
        drive_count;
        chk(16'(n), 16'h0004);
        i_ctrl.issue(CMD_READ, 2'h2, 1'b0);
        @(negedge clk_sys);
        i_ctrl.issue(CMD_BURST_STOP, 2'h3, 1'b0);
        drive_count;
        chk(16'(n), 16'h0002);
        i_ctrl.issue(CMD_WRITE, 2'h2, 1'b0);
        chk(commandViolation, 1'b0);
        $display("read test done");
    endtask : t_read
    task t_all;
        i_ctrl.issue(CMD_REFRESH, 2'h0, 1'b0);
        chk(commandViolation, 1'b1);
        i_ctrl.issue(CMD_PRECHARGE, 2'h0, 1'b1);
        chk(bankStates, {4{BANK_CLOSING}});
        chk(deviceBusy, 1'b1);
        span(3, BANK_CLOSING, BANK_CLOSE_CYCLES_DEFAULT);
        chk(allBanksIdle, 1'b1);
        $display("close all test done");
    endtask : t_all
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (6) @(negedge clk_sys);
        resetn = 1'b1;
        // The clock enable must be seen high on two edges before a command decodes.
        @(negedge clk_sys);
        t_reset;
        t_global;
        t_bank;
        t_auto;
        t_read;
        t_all;
        report_and_stop;
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        bad_count++;
        report_and_stop;
    end
endmodule : ddr_bank_command_legality_bench
bind ddr_bank_command_legality ddr_legality_monitor #(.BANK_CLOSE_TIME_CYCLES(BANK_CLOSE_TIME_CYCLES),
    .ROW_TO_COLUMN_DELAY_CYCLES(ROW_TO_COLUMN_DELAY_CYCLES), .REFRESH_CYCLE_TIME_CYCLES(REFRESH_CYCLE_TIME_CYCLES),
    .CONFIG_LOAD_DELAY_CYCLES(CONFIG_LOAD_DELAY_CYCLES), .READ_LATENCY_COUNT(READ_LATENCY_COUNT)) i_mon (.clk_sys,
    .resetn, .clockEnable, .commandPins, .bankStates, .bankRowReady, .allBanksIdle, .deviceOp, .deviceBusy,
    .readDataDrive, .readBurstBank, .commandViolation, .reinitRequired);

/* ddr_controller_model.sv */
`timescale 1ns/10ps
module ddr_controller_model (
    // Clock.
    input wire logic clk_sys,
    // Command bus towards the memory.
    output logic clockEnable,
    output ddr_legality_pkg::command_pins_type commandPins
);
    import ddr_legality_pkg::*;
    // Select, row, column and write strobe levels, indexed by command.
    logic [3:0] codes [8] = '{4'h7, 4'h3, 4'h1, 4'h0, 4'h5, 4'h4, 4'h2, 4'h6};
    initial begin
        clockEnable = 1'b1;
        commandPins = 7'h7f;
    end
    // Called at a falling edge; the command stands for one rising edge, then deselect scrambles the idle lines.
    task issue(input command_type op, input logic [1:0] bank, input logic ap);
        commandPins = {codes[op], bank, ap};
        @(posedge clk_sys);
        commandPins <= {1'b1, ~commandPins[5:0]};
        @(negedge clk_sys);
    endtask : issue
endmodule : ddr_controller_model

/* ddr_legality_monitor.sv */
`timescale 1ns/10ps
module ddr_legality_monitor #(
    parameter int BANK_CLOSE_TIME_CYCLES = 3,
    parameter int ROW_TO_COLUMN_DELAY_CYCLES = 3,
    parameter int REFRESH_CYCLE_TIME_CYCLES = 8,
    parameter int CONFIG_LOAD_DELAY_CYCLES = 2,
    parameter int READ_LATENCY_COUNT = 2
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Command bus.
    input wire logic clockEnable,
    input wire ddr_legality_pkg::command_pins_type commandPins,
    // Status.
    input wire ddr_legality_pkg::bank_state_type [ddr_legality_pkg::BANK_COUNT-1:0] bankStates,
    input wire logic [ddr_legality_pkg::BANK_COUNT-1:0] bankRowReady,
    input wire logic allBanksIdle,
    input wire ddr_legality_pkg::global_op_type deviceOp,
    input wire logic deviceBusy,
    input wire logic readDataDrive,
    input wire logic [1:0] readBurstBank,
    input wire logic commandViolation,
    input wire logic reinitRequired
);
    import ddr_legality_pkg::*;
    logic [3:0] code;
    assign code = commandPins[6:3];
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    a_close_timing: assert property ($rose(bankStates[0] == BANK_CLOSING) |->
        ##BANK_CLOSE_TIME_CYCLES bankStates[0] == BANK_IDLE) else $error("bank close time wrong");
    a_open_timing: assert property ($rose(bankStates[0] == BANK_OPENING) |->
        bankStates[0] == BANK_OPENING [*3] ##1 bankStates[0] == BANK_ACTIVE) else $error("row open time wrong");
    a_auto_read_span: assert property ($rose(bankStates[1] == BANK_AUTO_ACCESS) && $past(commandPins.writeStrobeN) |->
        ##4 bankStates[1] == BANK_AUTO_CLOSING ##BANK_CLOSE_TIME_CYCLES bankStates[1] == BANK_IDLE)
        else $error("auto precharge read span wrong");
    a_refresh_busy: assert property ($rose(deviceOp == OP_REFRESH) |->
        ##REFRESH_CYCLE_TIME_CYCLES deviceOp == OP_READY) else $error("refresh time wrong");
    a_config_busy: assert property ($rose(deviceOp == OP_CONFIG_LOAD) |-> deviceBusy
        ##CONFIG_LOAD_DELAY_CYCLES deviceOp == OP_READY && allBanksIdle) else $error("config load time wrong");
    a_close_all_timing: assert property ($past(code == 4'h2 && commandPins.autoPrecharge && deviceOp == OP_READY)
        && !commandViolation |-> bankStates == {4{BANK_CLOSING}} ##BANK_CLOSE_TIME_CYCLES allBanksIdle)
        else $error("close all timing wrong");
    a_state_decode: assert property ((allBanksIdle == (bankStates == {4{BANK_IDLE}})) &&
        (!bankRowReady[0] || bankStates[0] == BANK_ACTIVE)) else $error("idle or ready decode wrong");
    a_read_window: assert property ($past(code == 4'h5 && deviceOp == OP_READY) && !commandViolation |->
        !readDataDrive [*2] ##1 readDataDrive && readBurstBank == $past(commandPins.bank, 3))
        else $error("read data window wrong");
    a_stop_cuts_read: assert property ($past(code == 4'h6) |->
        ##READ_LATENCY_COUNT !readDataDrive) else $error("burst stop did not end data");
    a_busy_bank_refused: assert property ($past(code == 4'h3 && bankStates[commandPins.bank] != BANK_IDLE) |->
        commandViolation) else $error("activate to busy bank accepted");
    a_violation_sticky: assert property (commandViolation |-> reinitRequired ##1 reinitRequired)
        else $error("restart flag not held");
    cover property (commandViolation);
    cover property (deviceOp == OP_REFRESH);
    cover property (readDataDrive);
endmodule : ddr_legality_monitor

/* ddr_legality_pkg.sv */
package ddr_legality_pkg;

    localparam int BANK_COUNT = 4;
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int POWER_STABLE_US = 200;
    localparam int POWER_STABLE_CYCLES = (POWER_STABLE_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int LOCK_CYCLES = 200;
    localparam int WRITE_LATENCY_CYCLES = 1;
    localparam int BANK_CLOSE_CYCLES_DEFAULT = 3;
    localparam int ROW_TO_COLUMN_CYCLES_DEFAULT = 3;
    localparam int REFRESH_CYCLE_CYCLES_DEFAULT = 8;
    localparam int CONFIG_LOAD_CYCLES_DEFAULT = 2;
    localparam int WRITE_RECOVERY_CYCLES_DEFAULT = 2;
    localparam int READ_LATENCY_DEFAULT = 2;
    localparam int BURST_LENGTH_DEFAULT = 4;
    localparam int BANK_COUNT_WIDTH = 8;
    localparam int GLOBAL_COUNT_WIDTH = 16;
    localparam int LOCK_COUNT_WIDTH = 8;
    localparam int BURST_COUNT_WIDTH = 6;
    localparam logic [BANK_COUNT_WIDTH-1:0] BANK_COUNT_RESET = 8'h00;
    localparam logic [GLOBAL_COUNT_WIDTH-1:0] GLOBAL_COUNT_RESET = 16'h0000;
    localparam logic [LOCK_COUNT_WIDTH-1:0] LOCK_COUNT_RESET = 8'h00;
    localparam logic [BURST_COUNT_WIDTH-1:0] BURST_COUNT_RESET = 6'h00;

    typedef enum logic [2:0] {
        BANK_IDLE,
        BANK_OPENING,
        BANK_ACTIVE,
        BANK_CLOSING,
        BANK_AUTO_ACCESS,
        BANK_AUTO_CLOSING
    } bank_state_type;

    typedef enum logic [1:0] {
        OP_POWER_WAIT,
        OP_READY,
        OP_REFRESH,
        OP_CONFIG_LOAD
    } global_op_type;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_ACTIVATE,
        CMD_REFRESH,
        CMD_CONFIG_LOAD,
        CMD_READ,
        CMD_WRITE,
        CMD_PRECHARGE,
        CMD_BURST_STOP
    } command_type;

    typedef struct packed {
        logic chipSelectN;
        logic rowStrobeN;
        logic columnStrobeN;
        logic writeStrobeN;
        logic [1:0] bank;
        logic autoPrecharge;
    } command_pins_type;

    typedef struct packed {
        command_type op;
        logic [1:0] bank;
        logic autoPrecharge;
    } command_decoded_type;

    typedef struct packed {
        bank_state_type state;
        logic [BANK_COUNT_WIDTH-1:0] count;
    } bank_tracker_state_type;

    typedef struct packed {
        global_op_type op;
        logic closeAll;
        logic [GLOBAL_COUNT_WIDTH-1:0] count;
        logic [LOCK_COUNT_WIDTH-1:0] lockCount;
        logic ckePrev;
        logic [BURST_COUNT_WIDTH-1:0] readEnd;
        logic [BURST_COUNT_WIDTH-1:0] writeEnd;
        logic [1:0] readBank;
        logic dataDrive;
        logic violation;
        logic reinit;
    } legality_state_type;

endpackage : ddr_legality_pkg
